//--- pkg/pmt_pkg.sv
package pmt_pkg;
    localparam int ADDR_W = 10;
    localparam int WORD_W = 14;
    localparam int DEPTH = 1024;
    localparam logic [9:0] RESET_VECTOR = 10'h000;
    localparam logic [1:0] LAST_PAGE = 2'h3;
    localparam logic [5:0] LATCH_RESET = 6'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] PTR_HI_RESET = 2'h0;
    typedef enum logic [1:0] {PMT_IDLE, PMT_FETCH, PMT_TAB2} pmt_state_t;
endpackage

//--- design/pmt_store.sv
`timescale 1ns/1ps
// 1K x 14 program store, synchronous read port plus one write port
module pmt_store #(
    parameter int AW = 10,
    parameter int DW = 14
) (
    input wire logic clk,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // registered read keeps data outputs on flip-flops
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end

    // write path used only by the serial programmer
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

//--- design/pmt_top.sv
`timescale 1ns/1ps
// program memory access: fetch, table read, programming and debug pin roles
module pmt_top #(
    parameter int AW = 10,
    parameter int DW = 14
) (
    input wire logic clk,
    input wire logic nrst,
    // core fetch side
    input wire logic fetch_req,
    input wire logic pc_load,
    input wire logic [AW-1:0] pc_load_val,
    input wire logic pcl_write,
    input wire logic [7:0] pcl_wdata,
    output logic [AW-1:0] pc,
    output logic [7:0] program_counter_low_byte,
    output logic [DW-1:0] instr_word,
    output logic instr_valid,
    // table pointer writes from core
    input wire logic tblp_write,
    input wire logic tbhp_write,
    input wire logic [7:0] ptr_wdata,
    output logic [7:0] table_ptr_low,
    output logic [1:0] table_ptr_high,
    // table read commands
    input wire logic tab_rd,
    input wire logic table_read_last_page_instr,
    input wire logic [7:0] tab_dest_in,
    output logic stall,
    output logic tab_done,
    output logic [7:0] tab_dest,
    output logic [7:0] tab_low_byte,
    output logic [7:0] table_high_byte_latch,
    // pin roles
    input wire logic in_circuit_programming,
    input wire logic on_chip_debug_support,
    input wire logic prog_serial_data_pin_in,
    output logic prog_serial_data_pin_out,
    output logic prog_serial_data_pin_oe,
    input wire logic prog_serial_clock_pin,
    input wire logic debug_link_out,
    input wire logic debug_link_drive,
    output logic debug_link_in,
    output logic debug_link_clk,
    input wire logic prog_link_out,
    input wire logic prog_link_drive,
    output logic prog_link_in,
    output logic prog_link_clk,
    input wire logic prog_wr_en,
    input wire logic [AW-1:0] prog_wr_addr,
    input wire logic [DW-1:0] prog_wr_data,
    input wire logic gpio_data_out,
    input wire logic gpio_data_oe_n,
    output logic gpio_data_in,
    output logic gpio_clk_in
);

    ////////////////////////////////////////////////////////////////////////
    // state
    pmt_pkg::pmt_state_t state_q;
    logic [AW-1:0] pc_q;
    logic [7:0] tblp_q;
    logic [1:0] tbhp_q;
    logic [5:0] table_high_byte_latch_q;
    logic [7:0] dest_q;
    logic [7:0] low_q;
    logic done_q;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    logic tab_start;
    logic fetch_taken;

    // a request in the second table cycle is dropped, not queued:
    // the core never issues one there, so queueing would only add area
    assign tab_start = (tab_rd | table_read_last_page_instr) && state_q != pmt_pkg::PMT_TAB2;

    // one store port, so a fetch that meets a table start loses;
    // the core sees stall and repeats the fetch next cycle
    assign fetch_taken = fetch_req && !tab_start;

    ////////////////////////////////////////////////////////////////////////
    // address formation
    // last-page form ignores the high pointer entirely, so code that
    // keeps its tables in the top page needs no high pointer setup
    function automatic logic [AW-1:0] tab_addr(input logic last, input logic [1:0] hi, input logic [7:0] lo);
        tab_addr = last ? {pmt_pkg::LAST_PAGE, lo} : {hi, lo};
    endfunction

    // store port is shared: a table read steals one fetch slot
    always_comb begin
        if (tab_start) begin
            rd_addr = tab_addr(table_read_last_page_instr, tbhp_q, tblp_q);
        end else begin
            rd_addr = pc_q;
        end
    end

    // writes only pass while programming owns the pins, so a stray
    // write strobe in normal running cannot corrupt code
    // limitation: reads and writes share no ordering, writer must wait
    pmt_store #(
        .AW(AW),
        .DW(DW)
    ) u_store (
        .clk(clk),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_en(prog_wr_en & in_circuit_programming),
        .wr_addr(prog_wr_addr),
        .wr_data(prog_wr_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencing: a table op occupies two cycles
    // first cycle addresses the store, second cycle moves the word out;
    // fetch state is kept only so a debugger can see the port is busy
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= pmt_pkg::PMT_IDLE;
        end else if (tab_start) begin
            state_q <= pmt_pkg::PMT_TAB2;
        end else if (fetch_req) begin
            state_q <= pmt_pkg::PMT_FETCH;
        end else begin
            state_q <= pmt_pkg::PMT_IDLE;
        end
    end

    assign stall = tab_start;

    // program counter, reset vector at 000
    // load beats low-byte write beats increment; a low-byte write keeps
    // the page, so short jumps cannot leave the current 256 words
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pc_q <= pmt_pkg::RESET_VECTOR;
        end else if (pc_load) begin
            pc_q <= pc_load_val;
        end else if (pcl_write) begin
            pc_q <= {pc_q[AW-1:8], pcl_wdata};
        end else if (fetch_taken) begin
            pc_q <= pc_q + 1'b1;
        end
    end

    assign pc = pc_q;
    assign program_counter_low_byte = pc_q[7:0];

    // instruction word valid one cycle after fetch
    // the word itself is the store's own output register, so it only
    // holds for the valid cycle; the core must latch it there
    always_ff @(posedge clk) begin
        if (!nrst) begin
            instr_valid <= 1'b0;
        end else begin
            instr_valid <= fetch_taken;
        end
    end
    assign instr_word = rd_data;

    // table pointers
    // both may be written in one cycle from the same data byte; the high
    // pointer keeps only the two bits that reach the store
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tblp_q <= pmt_pkg::BYTE_RESET;
            tbhp_q <= pmt_pkg::PTR_HI_RESET;
        end else begin
            if (tblp_write) begin
                tblp_q <= ptr_wdata;
            end
            if (tbhp_write) begin
                tbhp_q <= ptr_wdata[1:0];
            end
        end
    end
    assign table_ptr_low = tblp_q;
    assign table_ptr_high = tbhp_q;

    ////////////////////////////////////////////////////////////////////////
    // table read results; latch has no write path from software
    // an interrupt handler reading a table overwrites the latch; the
    // block cannot save it, software has to mask interrupts around reads
    // target register number travels with the data so the core needs
    // no copy of its own
    always_ff @(posedge clk) begin
        if (!nrst) begin
            table_high_byte_latch_q <= pmt_pkg::LATCH_RESET;
            low_q <= pmt_pkg::BYTE_RESET;
            dest_q <= pmt_pkg::BYTE_RESET;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (tab_start) begin
                dest_q <= tab_dest_in;
            end
            if (state_q == pmt_pkg::PMT_TAB2) begin
                low_q <= rd_data[7:0];
                table_high_byte_latch_q <= rd_data[DW-1:8];
                done_q <= 1'b1;
            end
        end
    end

    assign tab_done = done_q;
    assign tab_dest = dest_q;
    assign tab_low_byte = low_q;
    // top two bits pad with zero since the word is only 14 bits
    assign table_high_byte_latch = {2'h0, table_high_byte_latch_q};

    ////////////////////////////////////////////////////////////////////////
    // shared pins: programming and debug own them over normal functions
    typedef enum logic [1:0] {OWN_GPIO, OWN_PROG, OWN_DEBUG} pmt_owner_t;

    // decoded in one place so the output mux and input steering agree;
    // programming outranks debug so a writer can always recover a part
    function automatic pmt_owner_t pin_owner(input logic prog_mode, input logic debug_mode);
        if (prog_mode) begin
            pin_owner = OWN_PROG;
        end else if (debug_mode) begin
            pin_owner = OWN_DEBUG;
        end else begin
            pin_owner = OWN_GPIO;
        end
    endfunction

    pmt_owner_t owner;
    logic link_owned;
    assign owner = pin_owner(in_circuit_programming, on_chip_debug_support);
    assign link_owned = owner != OWN_GPIO;

    // data pin driver; oe low means the block drives the pin
    always_comb begin
        prog_serial_data_pin_out = gpio_data_out;
        prog_serial_data_pin_oe = gpio_data_oe_n;
        unique case (owner)
            OWN_PROG: begin
                prog_serial_data_pin_out = prog_link_out;
                prog_serial_data_pin_oe = ~prog_link_drive;
            end
            OWN_DEBUG: begin
                prog_serial_data_pin_out = debug_link_out;
                prog_serial_data_pin_oe = ~debug_link_drive;
            end
            OWN_GPIO: begin
                prog_serial_data_pin_out = gpio_data_out;
                prog_serial_data_pin_oe = gpio_data_oe_n;
            end
            default: begin
                // unused code: release the pin rather than guess a driver
                prog_serial_data_pin_out = 1'b0;
                prog_serial_data_pin_oe = 1'b1;
            end
        endcase
    end

    // inputs go to exactly one consumer; the others see a quiet 0,
    // so pin activity cannot reach a function that is parked
    always_comb begin
        prog_link_in = 1'b0;
        prog_link_clk = 1'b0;
        debug_link_in = 1'b0;
        debug_link_clk = 1'b0;
        gpio_data_in = 1'b0;
        gpio_clk_in = 1'b0;
        unique case (owner)
            OWN_PROG: begin
                prog_link_in = prog_serial_data_pin_in;
                prog_link_clk = prog_serial_clock_pin;
            end
            OWN_DEBUG: begin
                debug_link_in = prog_serial_data_pin_in;
                debug_link_clk = prog_serial_clock_pin;
            end
            OWN_GPIO: begin
                gpio_data_in = prog_serial_data_pin_in;
                gpio_clk_in = prog_serial_clock_pin;
            end
            default: begin
            end
        endcase
    end
endmodule

//--- bench/pmt_top_properties.sv
`timescale 1ns/1ps
// watches the core-facing side of the program memory block
module pmt_top_properties #(
    parameter int AW = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic fetch_req,
    input wire logic stall,
    input wire logic tab_done,
    input wire logic instr_valid,
    input wire logic [AW-1:0] pc,
    input wire logic [7:0] program_counter_low_byte,
    input wire logic [7:0] table_high_byte_latch,
    input wire logic in_circuit_programming,
    input wire logic on_chip_debug_support,
    input wire logic gpio_data_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    // a table op is one quiet cycle then the done pulse
    sequence tab_finish;
        !tab_done ##1 tab_done;
    endsequence
    a_done_two_cycles: assert property (stall |=> tab_finish) else $error("table op not two cycles");
    a_done_one_pulse: assert property (tab_done |=> !tab_done) else $error("done held too long");
    a_latch_on_read: assert property ($changed(table_high_byte_latch) |-> tab_done) else $error("latch moved");
    a_latch_top_zero: assert property (table_high_byte_latch[7:6] == 2'h0) else $error("latch top set");
    // no disable here: the check starts inside reset on purpose
    a_reset_vector: assert property (disable iff (1'b0) !nrst |=> pc == '0) else $error("pc not 000");
    a_pcl_mirror: assert property (program_counter_low_byte == pc[7:0]) else $error("pc low byte differs");
    a_valid_after_fetch: assert property (instr_valid |-> $past(fetch_req) && !$past(stall)) else $error("bad valid");
    a_modes_block_gpio: assert property (in_circuit_programming || on_chip_debug_support |-> !gpio_data_in)
        else $error("gpio not blocked");
endmodule
bind pmt_top pmt_top_properties #(.AW(AW)) chk_u (.*);

//--- bench/pmt_core_model.sv
`timescale 1ns/1ps
// core execute stage: issues table reads one at a time
module pmt_core_model (
    input wire logic clk,
    output logic tab_rd,
    output logic table_read_last_page_instr,
    output logic [7:0] tab_dest_in
);
    // quiet command lines from time zero
    initial begin
        tab_rd = 1'b0;
        table_read_last_page_instr = 1'b0;
        tab_dest_in = 8'h00;
    end
    // one-cycle command; no nesting, as if interrupts were masked
    task automatic issue(input logic last, input logic [7:0] dest);
        @(negedge clk);
        tab_rd = !last;
        table_read_last_page_instr = last;
        tab_dest_in = dest;
        @(negedge clk);
        tab_rd = 1'b0;
        table_read_last_page_instr = 1'b0;
        tab_dest_in = ~dest; // stale target would hide a missed capture
    endtask
endmodule

//--- bench/program_memory_table_read_test.sv
`timescale 1ns/1ps
module program_memory_table_read_test;
    logic clk, nrst, fetch_req, pc_load, pcl_write, tblp_write, tbhp_write, ext_d, prog_wr_en, gpio_data_out;
    logic in_circuit_programming, on_chip_debug_support, prog_serial_clock_pin, prog_serial_data_pin_in;
    logic debug_link_out, debug_link_drive, prog_link_out, prog_link_drive, gpio_data_oe_n;
    logic [9:0] pc_load_val, prog_wr_addr, pc;
    logic [7:0] pcl_wdata, ptr_wdata, program_counter_low_byte, table_ptr_low, tab_dest_in, tab_dest;
    logic [7:0] tab_low_byte, table_high_byte_latch;
    logic [13:0] prog_wr_data, instr_word;
    logic [1:0] table_ptr_high;
    logic instr_valid, tab_rd, table_read_last_page_instr, stall, tab_done, prog_serial_data_pin_out;
    logic prog_serial_data_pin_oe, debug_link_in, debug_link_clk, prog_link_in, prog_link_clk;
    logic gpio_data_in, gpio_clk_in;
    logic [9:0] addrs [3] = '{10'h006, 10'h306, 10'h145};
    logic [13:0] words [3] = '{14'h1b7e, 14'h2a5c, 14'h3fc3};
    int mismatches = 0;
    int tests_run = 0;
    pmt_top dut_u (.*);
    pmt_core_model core_u (.*);
    // released pin floats to the outside level
    assign prog_serial_data_pin_in = prog_serial_data_pin_oe ? ext_d : prog_serial_data_pin_out;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_program();
        check("pc after reset", pc, 0);
        in_circuit_programming = 1'b1;
        prog_wr_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            prog_wr_addr = addrs[i];
            prog_wr_data = words[i];
            @(negedge clk);
        end
        prog_wr_en = 1'b0;
        in_circuit_programming = 1'b0;
        $display("test program done");
    endtask
    task automatic do_table(input logic [1:0] hi, input logic [7:0] lo, input logic last, input int k);
        tbhp_write = 1'b1;
        ptr_wdata = {6'h00, hi};
        @(negedge clk);
        tbhp_write = 1'b0;
        tblp_write = 1'b1;
        ptr_wdata = lo;
        @(negedge clk);
        tblp_write = 1'b0;
        check("pointer", {table_ptr_high, table_ptr_low}, {hi, lo});
        core_u.issue(last, lo);
        check("early done", tab_done, 0);
        @(negedge clk);
        check("done", tab_done, 1);
        check("low byte", tab_low_byte, words[k][7:0]);
        check("latch", table_high_byte_latch, words[k][13:8]);
        check("dest", tab_dest, lo);
    endtask
    task automatic t_tables();
        do_table(2'h0, 8'h06, 1'b0, 0);
        do_table(2'h0, 8'h06, 1'b1, 1);
        do_table(2'h1, 8'h45, 1'b0, 2);
        $display("test tables done");
    endtask
    task automatic t_fetch();
        logic [7:0] held;
        held = table_high_byte_latch;
        pc_load = 1'b1;
        pc_load_val = 10'h1ff;
        @(negedge clk);
        pc_load = 1'b0;
        pcl_write = 1'b1;
        pcl_wdata = 8'h45;
        @(negedge clk);
        pcl_write = 1'b0;
        check("pc", pc, 16'h0145);
        fetch_req = 1'b1;
        @(negedge clk);
        fetch_req = 1'b0;
        for (int i = 0; i < 4 && instr_valid !== 1'b1; i++)
            @(negedge clk);
        check("fetched word", instr_word, words[2]);
        check("latch kept", table_high_byte_latch, held);
        // fetch held high across a table start: start cycle refuses it
        held = pc[7:0];
        fetch_req = 1'b1;
        core_u.issue(1'b0, 8'h21);
        check("pc held in start", pc, {2'h1, held + 8'h01});
        check("refused fetch", instr_valid, 0);
        fetch_req = 1'b0;
        @(negedge clk);
        check("done after stall", tab_done, 1);
        check("dest after stall", tab_dest, 8'h21);
        $display("test fetch done");
    endtask
    task automatic t_pins();
        ext_d = 1'b1;
        prog_serial_clock_pin = 1'b1;
        in_circuit_programming = 1'b1;
        @(negedge clk);
        check("prog clk", prog_link_clk, 1);
        check("prog data", prog_link_in, 1);
        prog_link_drive = 1'b1;
        @(negedge clk);
        check("pin oe", prog_serial_data_pin_oe, 0);
        check("pin out", prog_serial_data_pin_out, 0);
        in_circuit_programming = 1'b0;
        on_chip_debug_support = 1'b1;
        @(negedge clk);
        check("debug clk", debug_link_clk, 1);
        check("debug data", debug_link_in, 1);
        check("gpio clk", gpio_clk_in, 0);
        debug_link_drive = 1'b1;
        debug_link_out = 1'b1;
        @(negedge clk);
        check("debug oe", prog_serial_data_pin_oe, 0);
        check("debug out", prog_serial_data_pin_out, 1);
        debug_link_drive = 1'b0;
        debug_link_out = 1'b0;
        on_chip_debug_support = 1'b0;
        @(negedge clk);
        check("gpio data", gpio_data_in, 1);
        $display("test pins done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog well past the few dozen cycles the run needs
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    // main sequence; debug link lines stay tied until t_pins
    initial begin
        {fetch_req, pc_load, pcl_write, tblp_write, tbhp_write, ext_d, prog_wr_en, gpio_data_out} = '0;
        {in_circuit_programming, on_chip_debug_support, prog_serial_clock_pin, prog_link_out} = '0;
        {debug_link_out, debug_link_drive, prog_link_drive, pc_load_val, prog_wr_addr} = '0;
        {pcl_wdata, ptr_wdata, prog_wr_data} = '0;
        gpio_data_oe_n = 1'b1;
        nrst = 1'b0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        t_program();
        t_tables();
        t_fetch();
        t_pins();
        end_of_test();
    end
endmodule
